// [core/udu_divide_unit.sv]
// Unsigned word and long divide execution unit with its decoder.
// Assumes a register file answering in the same cycle as its read strobe,
// an address unit answering memory operand requests, and FCW flags
// held outside.
`timescale 1ns/1ps

// What this block does
// - Zero divisor: destination kept, V and Z set, C and S cleared.
// - Quotient too large: destination kept, Z and S cleared.
// - Quotient fits: quotient and remainder written to destination.
// - Successful divide clears V and C.
// - Successful divide sets S and Z from the quotient.
// - Long memory form: prefix, opcode mode 01 op 011010, 1-3 ext words.
// - Indirect pointer is a word register in compact mode.
// - Quotient in low half, remainder in high half, source kept.
// - Unsigned: 32/16 word form, 64/32 long form.
module udu_divide_unit
   import udu_pkg::*;
(
   // Clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic CLK_EN,
   // Instruction word stream
   input wire logic INSN_VALID,
   input wire logic [15:0] INSN_WORD,
   input wire logic [1:0] EXT_WORDS,
   input wire logic COMPACT_MODE,
   output logic INSN_READY,
   // Register file
   output logic RF_RD,
   output logic [3:0] RF_DST_SEL,
   output logic [3:0] RF_SRC_SEL,
   output logic RF_LONG,
   input wire logic [63:0] RF_DST_DATA,
   input wire logic [31:0] RF_SRC_DATA,
   output logic WB_VALID,
   output logic [3:0] WB_SEL,
   output logic WB_LONG,
   output logic [63:0] WB_DATA,
   // Memory operand
   output logic MEM_REQ,
   output logic MEM_INDIRECT,
   output logic [3:0] MEM_FIELD,
   output logic MEM_PTR_WORD,
   output logic [1:0] MEM_EXT_COUNT,
   output logic [47:0] MEM_EXT,
   input wire logic MEM_VALID,
   input wire logic [31:0] MEM_DATA,
   // Flags and trap
   output logic FLAG_WE,
   output udu_flags_t FLAGS,
   output logic OVF_TRAP,
   // Register port and interrupt
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic IRQ
);

   typedef enum {S_IDLE, S_OPC, S_IMM_HI, S_IMM_LO, S_EXT, S_MEM,
                 S_RDREG, S_CAPT, S_CHECK, S_DIVIDE} udu_state_t;

   udu_state_t state;
   udu_opcode_t opc;
   logic [31:0] src_val;
   logic [63:0] dividend;
   logic [1:0] ext_left;
   logic [1:0] ctrl;
   logic [3:0] status;
   logic [3:0] mask;
   logic [31:0] last_result;
   logic core_start;

   // ==================================================================
   // Decode
   function automatic logic op_is_divide(input logic [5:0] op);
      op_is_divide = (op == OP_WORD_DIV) || (op == OP_LONG_DIV);
   endfunction

   function automatic logic op_is_long(input logic [5:0] op);
      op_is_long = (op == OP_LONG_DIV);
   endfunction

   wire udu_opcode_t in_opc = INSN_WORD;
   wire in_long = op_is_long(in_opc.op);
   wire is_long = op_is_long(opc.op);
   wire opc_legal = op_is_divide(in_opc.op) && (in_opc.mode != 2'h3);
   wire take = CLK_EN && INSN_VALID && INSN_READY;
   wire prefix_ok = INSN_WORD == PREFIX_WORD;
   wire is_imm = (in_opc.mode == MODE_IM_IR) && (in_opc.src == 4'h0);

   // ==================================================================
   // Outcome checks
   wire [31:0] divisor = is_long ? src_val : {16'h0, src_val[15:0]};
   wire div_zero = divisor == 32'h0;
   // quotient too large when high half reaches divisor
   wire quot_ovf = is_long ? (dividend[63:32] >= divisor)
                           : ({16'h0, dividend[31:16]} >= divisor);

   wire core_done;
   wire [31:0] core_quot;
   wire [31:0] core_rem;

   udu_div_core u_core
   (
      .clk(CORE_CLK),
      .nrst(NRST),
      .ce(CLK_EN),
      .start(core_start),
      .is_long(is_long),
      .dividend(dividend),
      .divisor(divisor),
      .busy(),
      .done(core_done),
      .quot(core_quot),
      .rem(core_rem)
   );

   wire [63:0] result = is_long ? {core_rem, core_quot}
                                : {32'h0, core_rem[15:0], core_quot[15:0]};
   wire q_zero = is_long ? (core_quot == 32'h0)
                         : (core_quot[15:0] == 16'h0);
   wire q_sign = is_long ? core_quot[31] : core_quot[15];

   wire check_now = CLK_EN && (state == S_CHECK);
   wire fail_zero = check_now && div_zero;
   wire fail_ovf = check_now && !div_zero && quot_ovf;
   wire finish = CLK_EN && (state == S_DIVIDE) && core_done;
   wire bad_opc = take && (state == S_OPC) && !opc_legal;

   // ==================================================================
   // Register port decode
   wire wr_status = CLK_EN && REG_WR && (REG_ADDR == REG_STATUS);
   wire [3:0] events = {bad_opc, fail_ovf, fail_zero,
                        finish | fail_zero | fail_ovf};
   wire [3:0] clr = wr_status ? REG_WDATA[3:0] : 4'h0;
   // Events win over a simultaneous write-one clear.
   wire [3:0] next_status = (status & ~clr) | events;
   wire [31:0] rd_mux =
      (REG_ADDR == REG_CTRL) ? {30'h0, ctrl} :
      (REG_ADDR == REG_STATUS) ? {28'h0, status} :
      (REG_ADDR == REG_MASK) ? {28'h0, mask} :
      (REG_ADDR == REG_RESULT) ? last_result : 32'h0;

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ctrl <= CTRL_RESET;
         status <= STATUS_RESET;
         mask <= MASK_RESET;
         REG_RDATA <= 32'h0;
         IRQ <= 1'b0;
      end
      else if (CLK_EN)
      begin
         status <= next_status;
         IRQ <= |(next_status & mask);
         REG_RDATA <= REG_RD ? rd_mux : 32'h0;
         if (REG_WR && (REG_ADDR == REG_CTRL))
            ctrl <= REG_WDATA[1:0];
         if (REG_WR && (REG_ADDR == REG_MASK))
            mask <= REG_WDATA[3:0];
      end
   end

   // ==================================================================
   // Instruction sequencer
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state <= S_IDLE;
         opc <= '0;
         src_val <= 32'h0;
         dividend <= 64'h0;
         ext_left <= 2'h0;
         core_start <= 1'b0;
         INSN_READY <= 1'b0;
         RF_RD <= 1'b0;
         RF_DST_SEL <= 4'h0;
         RF_SRC_SEL <= 4'h0;
         RF_LONG <= 1'b0;
         MEM_REQ <= 1'b0;
         MEM_INDIRECT <= 1'b0;
         MEM_FIELD <= 4'h0;
         MEM_PTR_WORD <= 1'b0;
         MEM_EXT_COUNT <= 2'h0;
         MEM_EXT <= 48'h0;
      end
      else if (CLK_EN)
      begin
         core_start <= 1'b0;
         RF_RD <= 1'b0;
         MEM_REQ <= 1'b0;
         case (state)
            S_IDLE:
            begin
               INSN_READY <= ctrl[CTRL_EN_BIT];
               if (take && prefix_ok)
                  state <= S_OPC;
            end
            S_OPC:
            begin
               if (take)
               begin
                  opc <= in_opc;
                  MEM_FIELD <= in_opc.src;
                  MEM_EXT_COUNT <= EXT_WORDS;
                  ext_left <= EXT_WORDS;
                  MEM_INDIRECT <= 1'b0;
                  MEM_PTR_WORD <= COMPACT_MODE;
                  if (!opc_legal)
                     state <= S_IDLE;
                  else if (in_opc.mode == MODE_REG)
                  begin
                     INSN_READY <= 1'b0;
                     state <= S_RDREG;
                  end
                  else if (is_imm)
                     state <= in_long ? S_IMM_HI : S_IMM_LO;
                  else if (in_opc.mode == MODE_IM_IR)
                  begin
                     INSN_READY <= 1'b0;
                     MEM_INDIRECT <= 1'b1;
                     MEM_REQ <= 1'b1;
                     state <= S_MEM;
                  end
                  else
                  begin
                     if (EXT_WORDS == 2'h0)
                     begin
                        ext_left <= 2'h1;
                        MEM_EXT_COUNT <= 2'h1;
                     end
                     state <= S_EXT;
                  end
               end
            end
            S_IMM_HI:
            begin
               if (take)
               begin
                  src_val[31:16] <= INSN_WORD;
                  state <= S_IMM_LO;
               end
            end
            S_IMM_LO:
            begin
               if (take)
               begin
                  src_val[15:0] <= INSN_WORD;
                  INSN_READY <= 1'b0;
                  state <= S_RDREG;
               end
            end
            S_EXT:
            begin
               if (take)
               begin
                  MEM_EXT <= {MEM_EXT[31:0], INSN_WORD};
                  ext_left <= ext_left - 2'h1;
                  if (ext_left == 2'h1)
                  begin
                     INSN_READY <= 1'b0;
                     MEM_REQ <= 1'b1;
                     state <= S_MEM;
                  end
               end
            end
            S_MEM:
            begin
               if (MEM_VALID)
               begin
                  src_val <= MEM_DATA;
                  state <= S_RDREG;
               end
            end
            S_RDREG:
            begin
               RF_RD <= 1'b1;
               RF_DST_SEL <= opc.dst;
               RF_SRC_SEL <= opc.src;
               RF_LONG <= is_long;
               state <= S_CAPT;
            end
            S_CAPT:
            begin
               dividend <= is_long ? RF_DST_DATA : {32'h0, RF_DST_DATA[31:0]};
               if (opc.mode == MODE_REG)
                  src_val <= is_long ? RF_SRC_DATA
                                     : {16'h0, RF_SRC_DATA[15:0]};
               state <= S_CHECK;
            end
            S_CHECK:
            begin
               if (div_zero || quot_ovf)
                  state <= S_IDLE;
               else
               begin
                  core_start <= 1'b1;
                  state <= S_DIVIDE;
               end
            end
            S_DIVIDE:
            begin
               if (core_done)
                  state <= S_IDLE;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   // ==================================================================
   // Write-back and flags
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         WB_VALID <= 1'b0;
         WB_SEL <= 4'h0;
         WB_LONG <= 1'b0;
         WB_DATA <= 64'h0;
         FLAG_WE <= 1'b0;
         FLAGS <= '0;
         OVF_TRAP <= 1'b0;
         last_result <= 32'h0;
      end
      else if (CLK_EN)
      begin
         WB_VALID <= 1'b0;
         FLAG_WE <= 1'b0;
         OVF_TRAP <= 1'b0;
         if (fail_zero)
         begin
            // no write, V Z set, C S clear
            FLAG_WE <= 1'b1;
            FLAGS <= '{v: 1'b1, c: 1'b0, z: 1'b1, s: 1'b0};
            OVF_TRAP <= ctrl[CTRL_TRAP_BIT];
         end
         else if (fail_ovf)
         begin
            // no write, V set, C Z S clear
            FLAG_WE <= 1'b1;
            FLAGS <= '{v: 1'b1, c: 1'b0, z: 1'b0, s: 1'b0};
            OVF_TRAP <= ctrl[CTRL_TRAP_BIT];
         end
         else if (finish)
         begin
            WB_VALID <= 1'b1;
            WB_SEL <= opc.dst;
            WB_LONG <= is_long;
            WB_DATA <= result;
            last_result <= core_quot;
            FLAG_WE <= 1'b1;
            // V C clear, S Z from quotient
            FLAGS <= '{v: 1'b0, c: 1'b0, z: q_zero, s: q_sign};
         end
      end
   end

endmodule

// [core/udu_pkg.sv]
// Shared constants and types of the unsigned divide unit.
// Assumes one core clock domain and a plain register port.
package udu_pkg;

   // ==================================================================
   // Instruction encoding
   localparam logic [15:0] PREFIX_WORD = 16'h7A03;
   localparam logic [5:0] OP_WORD_DIV = 6'h1B;
   localparam logic [5:0] OP_LONG_DIV = 6'h1A;
   localparam logic [1:0] MODE_IM_IR = 2'h0;
   localparam logic [1:0] MODE_EAM = 2'h1;
   localparam logic [1:0] MODE_REG = 2'h2;

   // ==================================================================
   // Iteration counts, one quotient bit per cycle
   localparam logic [5:0] WORD_ITERS = 6'h10;
   localparam logic [5:0] LONG_ITERS = 6'h20;

   // ==================================================================
   // Register offsets and fields
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam logic [3:0] REG_RESULT = 4'hC;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_TRAP_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_ZDIV_BIT = 1;
   localparam int ST_OVF_BIT = 2;
   localparam int ST_ILL_BIT = 3;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // ==================================================================
   // Types
   typedef struct packed
   {
      logic [1:0] mode;
      logic [5:0] op;
      logic [3:0] src;
      logic [3:0] dst;
   } udu_opcode_t;

   typedef struct packed
   {
      logic v;
      logic c;
      logic z;
      logic s;
   } udu_flags_t;

endpackage

// [core/udu_div_core.sv]
// Iterative restoring divider, one quotient bit per enabled clock.
// Assumes the caller has already rejected zero divisors and overflow.
`timescale 1ns/1ps

module udu_div_core
   import udu_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Request
   input wire logic start,
   input wire logic is_long,
   input wire logic [63:0] dividend,
   input wire logic [31:0] divisor,
   // Result
   output logic busy,
   output logic done,
   output logic [31:0] quot,
   output logic [31:0] rem
);

   logic [32:0] r;
   logic [31:0] q;
   logic [31:0] d;
   logic [5:0] left;

   // ==================================================================
   // Shift-subtract step
   wire [32:0] shifted = {r[31:0], q[31]};
   wire fits = shifted >= {1'b0, d};
   wire [32:0] next_r = fits ? shifted - {1'b0, d} : shifted;
   wire [31:0] next_q = {q[30:0], fits};

   assign quot = q;
   assign rem = r[31:0];

   // ==================================================================
   // Sequencer
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r <= 33'h0;
         q <= 32'h0;
         d <= 32'h0;
         left <= 6'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         if (start)
         begin
            r <= is_long ? {1'b0, dividend[63:32]}
                         : {17'h0, dividend[31:16]};
            q <= is_long ? dividend[31:0] : {dividend[15:0], 16'h0};
            d <= is_long ? divisor : {16'h0, divisor[15:0]};
            left <= is_long ? LONG_ITERS : WORD_ITERS;
            busy <= 1'b1;
         end
         else if (busy)
         begin
            r <= next_r;
            q <= next_q;
            left <= left - 6'h1;
            if (left == 6'h1)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule

// [dv/udu_far_model.sv]
// Far-side model: register file and memory operand source.
// Assumes the bench sets both operands before each divide starts.
`timescale 1ns/1ps

module udu_far_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Operands from the bench
   input wire logic [63:0] dd,
   input wire logic [31:0] ds,
   // Register file side
   input wire logic rf_rd,
   output logic [63:0] rf_dst_data,
   output logic [31:0] rf_src_data,
   // Memory side
   input wire logic mem_req,
   output logic mem_valid,
   output logic [31:0] mem_data
);
   // ==================================================================
   // Answers
   logic [2:0] cnt;

   // unsigned operand supply
   // The register file answers while its read strobe is high, since the
   // unit samples at the edge that ends the strobe cycle.
   // Data is valid only in its answer cycle and inverted elsewhere.
   assign rf_dst_data = rf_rd ? dd : ~dd;
   assign rf_src_data = rf_rd ? ds : ~ds;
   assign mem_data = mem_valid ? ds : ~ds;

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mem_valid <= 1'b0;
         cnt <= 3'h0;
      end
      else
      begin
         mem_valid <= (cnt == 3'h1);
         if (mem_req)
            cnt <= 3'(1 + $urandom % 4);
         else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
      end
   end
endmodule

// [dv/udu_asserts.sv]
// Checker of result, flag and port timing of the divide unit.
// Assumes it is bound to udu_divide_unit and sees its ports only.
`timescale 1ns/1ps

module udu_asserts
   import udu_pkg::*;
(
   // Clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic CLK_EN,
   // Observed outputs and strobes
   input wire logic INSN_READY,
   input wire logic RF_RD,
   input wire logic WB_VALID,
   input wire logic WB_LONG,
   input wire logic [63:0] WB_DATA,
   input wire logic MEM_REQ,
   input wire logic FLAG_WE,
   input wire udu_flags_t FLAGS,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);

   // ==================================================================
   // Outcomes
   wb_clean_a: assert property (
      WB_VALID |-> FLAG_WE && !FLAGS.v && !FLAGS.c)
      else $error("write-back with dirty flags");
   fail_keep_a: assert property (
      FLAG_WE && FLAGS.v |-> !WB_VALID && !FLAGS.c && !FLAGS.s)
      else $error("failed divide wrote or set flags");
   word_zs_a: assert property (
      WB_VALID && !WB_LONG |-> FLAGS.z == (WB_DATA[15:0] == 16'h0)
      && FLAGS.s == WB_DATA[15])
      else $error("word flags do not follow quotient");
   long_zs_a: assert property (
      WB_VALID && WB_LONG |-> FLAGS.z == (WB_DATA[31:0] == 32'h0)
      && FLAGS.s == WB_DATA[31])
      else $error("long flags do not follow quotient");
   word_high_a: assert property (
      WB_VALID && !WB_LONG |-> WB_DATA[63:32] == 32'h0)
      else $error("word result upper half not zero");
   ready_low_a: assert property (WB_VALID |-> !INSN_READY)
      else $error("ready during write-back");

   // ==================================================================
   // Port timing
   mem_pulse_a: assert property (MEM_REQ && CLK_EN |=> !MEM_REQ)
      else $error("memory request longer than one cycle");
   rf_pulse_a: assert property (RF_RD && CLK_EN |=> !RF_RD)
      else $error("register read longer than one cycle");
   rdata_idle_a: assert property (
      $past(CLK_EN) && !$past(REG_RD) |-> REG_RDATA == 32'h0)
      else $error("read data without read");
endmodule

bind udu_divide_unit udu_asserts i_chk (
   .CORE_CLK(CORE_CLK), .NRST(NRST), .CLK_EN(CLK_EN),
   .INSN_READY(INSN_READY), .RF_RD(RF_RD), .WB_VALID(WB_VALID),
   .WB_LONG(WB_LONG), .WB_DATA(WB_DATA), .MEM_REQ(MEM_REQ),
   .FLAG_WE(FLAG_WE), .FLAGS(FLAGS), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA));

// [dv/tb_top.sv]
// Self-checking bench of the unsigned divide unit.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/1ps

module tb_top
   import udu_pkg::*;
;
   logic CORE_CLK, NRST, CLK_EN, INSN_VALID, COMPACT_MODE, INSN_READY;
   logic RF_RD, RF_LONG, WB_VALID, WB_LONG, MEM_REQ, MEM_INDIRECT;
   logic MEM_PTR_WORD, MEM_VALID, FLAG_WE, OVF_TRAP, IRQ, REG_WR, REG_RD;
   logic [1:0] EXT_WORDS, MEM_EXT_COUNT, e_cnt;
   logic [3:0] RF_DST_SEL, RF_SRC_SEL, WB_SEL, MEM_FIELD, REG_ADDR, e_dst;
   logic [15:0] INSN_WORD, e_ext;
   logic [31:0] RF_SRC_DATA, MEM_DATA, REG_WDATA, REG_RDATA, f_ds, d;
   logic [63:0] RF_DST_DATA, WB_DATA, f_dd;
   logic [47:0] MEM_EXT;
   logic [31:0] last_q;
   logic e_lg, e_ind, e_ptr;
   logic [3:0] e_src;
   udu_flags_t FLAGS;
   int n_mismatch, checks, n_trap, i, t0;
   longint unsigned q, r, dd, ds;

   always #5 CORE_CLK = ~CORE_CLK;

   udu_far_model i_far (.clk(CORE_CLK), .nrst(NRST), .dd(f_dd), .ds(f_ds),
      .rf_rd(RF_RD), .rf_dst_data(RF_DST_DATA), .rf_src_data(RF_SRC_DATA),
      .mem_req(MEM_REQ), .mem_valid(MEM_VALID), .mem_data(MEM_DATA));

   udu_divide_unit i_dut (.CORE_CLK(CORE_CLK), .NRST(NRST),
      .CLK_EN(CLK_EN), .INSN_VALID(INSN_VALID), .INSN_WORD(INSN_WORD),
      .EXT_WORDS(EXT_WORDS), .COMPACT_MODE(COMPACT_MODE),
      .INSN_READY(INSN_READY), .RF_RD(RF_RD), .RF_DST_SEL(RF_DST_SEL),
      .RF_SRC_SEL(RF_SRC_SEL), .RF_LONG(RF_LONG),
      .RF_DST_DATA(RF_DST_DATA), .RF_SRC_DATA(RF_SRC_DATA),
      .WB_VALID(WB_VALID), .WB_SEL(WB_SEL), .WB_LONG(WB_LONG),
      .WB_DATA(WB_DATA), .MEM_REQ(MEM_REQ), .MEM_INDIRECT(MEM_INDIRECT),
      .MEM_FIELD(MEM_FIELD), .MEM_PTR_WORD(MEM_PTR_WORD),
      .MEM_EXT_COUNT(MEM_EXT_COUNT), .MEM_EXT(MEM_EXT),
      .MEM_VALID(MEM_VALID), .MEM_DATA(MEM_DATA), .FLAG_WE(FLAG_WE),
      .FLAGS(FLAGS), .OVF_TRAP(OVF_TRAP), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .IRQ(IRQ));

   // ==================================================================
   // Checking and ending
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==================================================================
   // Port tasks
   task automatic send(input logic [15:0] w);
      INSN_VALID <= 1'b1;
      INSN_WORD <= w;
      @(posedge CORE_CLK);
      while (INSN_READY !== 1'b1)
         @(posedge CORE_CLK);
   endtask

   task automatic rw(input logic [3:0] a, input logic [31:0] v);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= v;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
      @(posedge CORE_CLK);
   endtask

   task automatic rr(input logic [3:0] a, input logic [31:0] exp);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      @(posedge CORE_CLK);
      chk(REG_RDATA, exp);
   endtask

   // Sends one divide, then compares its outcome with the integer model.
   task automatic div(input logic lg, input logic [1:0] md,
      input logic [3:0] sf, input logic [63:0] a, input logic [31:0] b);
      longint unsigned x, y;
      logic [3:0] ef;
      int k;
      x = lg ? a : a[31:0];
      y = lg ? b : b[15:0];
      e_lg = lg;
      e_dst = 4'($urandom);
      e_src = sf;
      e_ind = (md == MODE_IM_IR);
      e_ptr = 1'($urandom);
      e_cnt = 2'(1 + $urandom % 3);
      f_dd <= lg ? a : {~a[31:0], a[31:0]};
      f_ds <= lg ? b : {~b[15:0], b[15:0]};
      COMPACT_MODE <= e_ptr;
      EXT_WORDS <= e_cnt;
      send(PREFIX_WORD);
      send({md, lg ? OP_LONG_DIV : OP_WORD_DIV, sf, e_dst});
      if (md == MODE_IM_IR && sf == 4'h0)
      begin
         if (lg)
            send(b[31:16]);
         send(b[15:0]);
      end
      else if (md == MODE_EAM)
         for (k = 0; k < e_cnt; k++)
         begin
            e_ext = 16'($urandom);
            send(e_ext);
         end
      INSN_VALID <= 1'b0;
      for (k = 0; k < 200 && FLAG_WE !== 1'b1; k++)
         @(posedge CORE_CLK);
      if (k == 200)
      begin
         n_mismatch++;
         test_done();
      end
      ef = 4'hA;
      if (y != 0)
      begin
         q = x / y;
         r = x % y;
         ef = (q > (lg ? 64'hFFFFFFFF : 64'hFFFF)) ? 4'h8 :
            {2'b00, q == 0, lg ? q[31] : q[15]};
      end
      chk(FLAGS, ef);
      chk(WB_VALID, !ef[3]);
      if (!ef[3])
      begin
         chk(WB_DATA, lg ? {r[31:0], q[31:0]} : {r[15:0], q[15:0]});
         chk({WB_LONG, WB_SEL}, {lg, e_dst});
         last_q = q[31:0];
      end
   endtask

   always @(posedge CORE_CLK)
   begin
      if (OVF_TRAP === 1'b1)
         n_trap++;
      if (RF_RD === 1'b1)
         chk({RF_LONG, RF_DST_SEL, RF_SRC_SEL},
            {e_lg, e_dst, e_src});
      if (MEM_REQ === 1'b1)
         chk({MEM_INDIRECT, MEM_PTR_WORD, MEM_FIELD},
            {e_ind, e_ptr, e_src});
      if (MEM_REQ === 1'b1 && !e_ind)
         chk({MEM_EXT_COUNT, MEM_EXT[15:0]}, {e_cnt, e_ext});
   end

   // ==================================================================
   // Scenarios
   initial
   begin
      {CORE_CLK, NRST, INSN_VALID, COMPACT_MODE, REG_WR, REG_RD} = 6'h0;
      {EXT_WORDS, INSN_WORD, REG_ADDR, REG_WDATA} = 54'h0;
      CLK_EN = 1'b1;
      {f_dd, f_ds, n_mismatch, checks, n_trap} = 0;
      void'($urandom(32'h20BC2DC1));
      repeat (12) @(posedge CORE_CLK);
      NRST <= 1'b1;
      @(posedge CORE_CLK);
      rr(REG_CTRL, 32'h1);
      rr(REG_STATUS, 32'h0);
      rr(REG_MASK, 32'h0);
      rw(4'h2, 32'hFFFFFFFF);
      rr(4'h2, 32'h0);
      rw(REG_STATUS, 32'hF);
      div(1'b0, MODE_REG, 4'h3, 64'h1234, 32'h0);
      rr(REG_STATUS, 32'h3);
      rw(REG_MASK, 32'h2);
      // The interrupt follows the mask register one cycle after it lands.
      @(posedge CORE_CLK);
      chk(IRQ, 1'b1);
      rw(REG_STATUS, 32'h2);
      chk(IRQ, 1'b0);
      rw(REG_MASK, 32'h4);
      div(1'b0, MODE_REG, 4'h3, 64'h12340000, 32'h1234);
      rr(REG_STATUS, 32'h5);
      chk(IRQ, 1'b1);
      chk(n_trap, 0);
      rw(REG_CTRL, 32'h3);
      t0 = n_trap;
      div(1'b1, MODE_IM_IR, 4'h0, 64'h100000000, 32'h1);
      repeat (3) @(posedge CORE_CLK);
      chk(n_trap - t0, 1);
      rw(REG_STATUS, 32'hF);
      send(PREFIX_WORD);
      send({2'b11, OP_WORD_DIV, 8'h12});
      INSN_VALID <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      rr(REG_STATUS, 32'h8);
      // A clear offered while the enable is low must not land.
      CLK_EN <= 1'b0;
      rw(REG_STATUS, 32'hF);
      CLK_EN <= 1'b1;
      rr(REG_STATUS, 32'h8);
      div(1'b0, MODE_IM_IR, 4'h0, 64'hF00, 32'h81);
      div(1'b0, MODE_EAM, 4'h5, 64'h1233FFFF, 32'h1234);
      div(1'b0, MODE_IM_IR, 4'h2, 64'h5, 32'h9);
      div(1'b1, MODE_REG, 4'h4, 64'h80000000, 32'h1);
      div(1'b1, MODE_EAM, 4'h6, 64'h5, 32'h0);
      for (i = 0; i < 40; i++)
      begin
         ds = i[0] ? $urandom : $urandom % 32'h10000;
         ds = (i % 7 == 6) ? 0 : (ds == 0) ? 1 : ds;
         q = i[0] ? $urandom : $urandom % 32'h10000;
         r = (ds != 0) ? $urandom % ds : 0;
         dd = (i % 5 == 4) ? {$urandom, $urandom} : q * ds + r;
         t0 = (i >> 1) % 4;
         div(i[0], (t0 == 0) ? MODE_REG : (t0 == 3) ? MODE_EAM : MODE_IM_IR,
            (t0 == 1) ? 4'h0 : 4'(1 + $urandom % 15), dd, 32'(ds));
      end
      rr(REG_RESULT, last_q);
      test_done();
   end

   initial
   begin
      #1000000;
      n_mismatch++;
      test_done();
   end
endmodule
